// >>> hdl/dbc_ctrl_regs.sv
`include "dbc_defs.svh"

module dbc_ctrl_regs (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire dbc_pkg::dbc_func_t function_code,
   input wire logic uart_tx_select,
   input wire logic prev_primary_out,
   input wire logic spi_overrun,
   input wire logic spi_complete,
   input wire logic spi_tx_empty,
   input wire logic spi_rx_full,
   input wire logic tx_reg_empty,
   input wire logic tx_complete,
   input wire logic rx_reg_full,
   input wire logic rx_active,
   input wire logic rx_framing_error,
   input wire logic rx_overrun,
   input wire logic rx_parity_error,
   output logic function_enable,
   output logic [3:0] kill_select,
   output logic [3:0] start_select,
   output logic capture_int_enable,
   output logic terminal_count_full_width,
   output logic compare_extend,
   output logic compare_value_buffer_en,
   output logic pass_mode,
   output logic shift_mode,
   output logic software_trigger,
   output logic no_swallow_option,
   output logic bitbang_mode,
   output logic bitbang_clock,
   output logic deadband_reference,
   output logic serial_lsb_first,
   output logic serial_clock_phase,
   output logic serial_clock_polarity,
   output logic parity_enable,
   output logic parity_odd,
   output logic [3:0] repeat_count,
   output logic stop_polarity_invert,
   output logic [1:0] stop_behaviour_select,
   output logic kill_int_select,
   output logic trigger_polarity_invert,
   output logic [2:0] dead_time_width,
   output logic [4:0] serial_length,
   output logic serial_lsb_block,
   output logic serial_chained
);
   import dbc_pkg::*;

   // ------------------------------------------------------------
   // Field masks
   // ------------------------------------------------------------

   function automatic dbc_byte_t ctrl0_mask(input dbc_func_t fn);
      dbc_byte_t m;
      m = `DBC_RESET_VAL;
      unique case (fn)
         DBC_TIMER: m = `DBC_WM0_TIMER;
         DBC_COUNTER: m = `DBC_WM0_COUNTER;
         DBC_CHECKSUM: m = `DBC_WM0_CHECKSUM;
         DBC_DUAL_PULSE: m = `DBC_WM0_DUAL_PULSE;
         DBC_DEAD_TIME: m = `DBC_WM0_DEAD_TIME;
         DBC_ASYNC: m = `DBC_WM0_ASYNC;
         DBC_SERIAL: m = `DBC_WM0_SERIAL;
         DBC_DENSITY: m = `DBC_WM0_DENSITY;
      endcase
      return m;
   endfunction

   function automatic dbc_byte_t ctrl1_mask(input dbc_func_t fn);
      dbc_byte_t m;
      m = `DBC_RESET_VAL;
      unique case (fn)
         DBC_TIMER: m = `DBC_WM1_MULTI;
         DBC_COUNTER: m = `DBC_WM1_MULTI;
         DBC_CHECKSUM: m = `DBC_WM1_MULTI;
         DBC_DUAL_PULSE: m = `DBC_WM1_MULTI;
         DBC_DEAD_TIME: m = `DBC_WM1_DEAD_TIME;
         DBC_ASYNC: m = `DBC_WM1_ASYNC;
         DBC_SERIAL: m = `DBC_WM1_SERIAL;
         DBC_DENSITY: m = `DBC_WM1_DENSITY;
      endcase
      return m;
   endfunction

   function automatic logic has_kill_source(input dbc_func_t fn);
      logic r;
      r = 1'b0;
      unique case (fn)
         DBC_TIMER: r = 1'b1;
         DBC_COUNTER: r = 1'b1;
         DBC_CHECKSUM: r = 1'b1;
         DBC_DENSITY: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic has_kill_int(input dbc_func_t fn);
      logic r;
      r = 1'b0;
      unique case (fn)
         DBC_TIMER: r = 1'b1;
         DBC_COUNTER: r = 1'b1;
         DBC_CHECKSUM: r = 1'b1;
         DBC_DEAD_TIME: r = 1'b1;
         DBC_DENSITY: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------

   dbc_byte_t ctrl0;
   dbc_byte_t ctrl1;
   dbc_byte_t ctrl0_q;
   dbc_byte_t ctrl1_q;
   dbc_byte_t status0;
   dbc_byte_t next_rdata;
   logic wr_ctrl0;
   logic wr_ctrl1;

   assign wr_ctrl0 = reg_wr && (reg_addr == `DBC_ADDR_CTRL0);
   assign wr_ctrl1 = reg_wr && (reg_addr == `DBC_ADDR_CTRL1);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl0 <= `DBC_RESET_VAL;
      end else if (wr_ctrl0) begin
         ctrl0 <= reg_wdata & ctrl0_mask(function_code);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl1 <= `DBC_RESET_VAL;
      end else if (wr_ctrl1) begin
         ctrl1 <= reg_wdata & ctrl1_mask(function_code);
      end
   end

   // ------------------------------------------------------------
   // Control stage on the block clock
   // ------------------------------------------------------------

   // The mask is applied again here so a later change of function code
   // never exposes bits that the new function code's mask does not allow.
   // enable on clock edge
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl0_q <= `DBC_RESET_VAL;
      end else begin
         ctrl0_q <= ctrl0 & ctrl0_mask(function_code);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl1_q <= `DBC_RESET_VAL;
      end else begin
         ctrl1_q <= ctrl1 & ctrl1_mask(function_code);
      end
   end

   // ------------------------------------------------------------
   // Read-only status overlay
   // ------------------------------------------------------------

   always_comb begin
      status0 = `DBC_RESET_VAL;
      if (function_code == DBC_SERIAL) begin
         status0[`DBC_B0_OVERRUN] = spi_overrun;
         status0[`DBC_B0_COMPLETE] = spi_complete;
         status0[`DBC_B0_TX_EMPTY] = spi_tx_empty;
         status0[`DBC_B0_RX_FULL] = spi_rx_full;
      end else if (function_code == DBC_ASYNC && uart_tx_select) begin
         status0[`DBC_B0_COMPLETE] = tx_complete;
         status0[`DBC_B0_TX_EMPTY] = tx_reg_empty;
      end else if (function_code == DBC_ASYNC) begin
         status0[`DBC_B0_PARITY_ERR] = rx_parity_error;
         status0[`DBC_B0_OVERRUN] = rx_overrun;
         status0[`DBC_B0_FRAMING] = rx_framing_error;
         status0[`DBC_B0_RX_ACTIVE] = rx_active;
         status0[`DBC_B0_RX_FULL] = rx_reg_full;
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------

   always_comb begin
      next_rdata = `DBC_READ_NONE;
      if (reg_rd && reg_addr == `DBC_ADDR_CTRL0) begin
         next_rdata = (ctrl0 & ctrl0_mask(function_code)) | status0;
      end else if (reg_rd && reg_addr == `DBC_ADDR_CTRL1) begin
         next_rdata = ctrl1 & ctrl1_mask(function_code);
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= `DBC_READ_NONE;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Control register 0 fields
   // ------------------------------------------------------------

   assign function_enable = ctrl0_q[`DBC_B0_EN];

   // kill select field
   // Serial keeps its bit-order flag in bit 7, so only kill-capable codes pass the field
   assign kill_select = has_kill_source(function_code) ?
      ctrl0_q[`DBC_B0_SEL_HI:`DBC_B0_SEL_LO] : 4'h0;

   assign start_select = (function_code == DBC_DUAL_PULSE) ?
      ctrl0_q[`DBC_B0_SEL_HI:`DBC_B0_SEL_LO] : 4'h0;

   assign capture_int_enable = (function_code == DBC_TIMER) && ctrl0_q[`DBC_B0_OPT1];
   assign terminal_count_full_width = (function_code == DBC_TIMER) && ctrl0_q[`DBC_B0_OPT2];

   // Timer keeps the extension in bit 3; counter and dual pulse use bit 2
   always_comb begin
      compare_extend = 1'b0;
      unique case (function_code)
         DBC_TIMER: compare_extend = ctrl0_q[`DBC_B0_OPT3];
         DBC_COUNTER: compare_extend = ctrl0_q[`DBC_B0_OPT2];
         DBC_DUAL_PULSE: compare_extend = ctrl0_q[`DBC_B0_OPT2];
         default: compare_extend = 1'b0;
      endcase
   end

   assign compare_value_buffer_en = (function_code == DBC_COUNTER) && ctrl0_q[`DBC_B0_OPT1];

   assign pass_mode = (function_code == DBC_CHECKSUM) && ctrl0_q[`DBC_B0_OPT1];
   assign shift_mode = (function_code == DBC_CHECKSUM) && ctrl0_q[`DBC_B0_OPT2];

   assign software_trigger = (function_code == DBC_DUAL_PULSE) && ctrl0_q[`DBC_B0_OPT1];

   // combination with dead band is left to software, not blocked here
   assign no_swallow_option = (function_code == DBC_DUAL_PULSE) && ctrl0_q[`DBC_B0_OPT3];

   assign bitbang_mode = (function_code == DBC_DEAD_TIME) && ctrl0_q[`DBC_B0_OPT1];
   assign bitbang_clock = (function_code == DBC_DEAD_TIME) && ctrl0_q[`DBC_B0_OPT2];

   assign deadband_reference = bitbang_mode ? bitbang_clock : prev_primary_out;

   assign serial_lsb_first = (function_code == DBC_SERIAL) && ctrl0_q[`DBC_B0_LSB_FIRST];
   assign serial_clock_phase = (function_code == DBC_SERIAL) && ctrl0_q[`DBC_B0_OPT2];
   assign serial_clock_polarity = (function_code == DBC_SERIAL) && ctrl0_q[`DBC_B0_OPT1];

   assign parity_enable = (function_code == DBC_ASYNC) && ctrl0_q[`DBC_B0_OPT1];
   assign parity_odd = (function_code == DBC_ASYNC) && ctrl0_q[`DBC_B0_OPT2];

   // ------------------------------------------------------------
   // Control register 1 fields
   // ------------------------------------------------------------

   logic multi_fn;

   assign multi_fn = function_code == DBC_TIMER || function_code == DBC_COUNTER ||
      function_code == DBC_CHECKSUM;

   assign repeat_count = (multi_fn || function_code == DBC_DUAL_PULSE) ?
      ctrl1_q[`DBC_B1_RPT_HI:`DBC_B1_RPT_LO] : 4'h0;

   assign stop_polarity_invert = has_kill_source(function_code) && ctrl1_q[`DBC_B1_INV];

   assign stop_behaviour_select = multi_fn ? ctrl1_q[`DBC_B1_MD_HI:`DBC_B1_MD_LO] : 2'h0;

   assign kill_int_select = has_kill_int(function_code) && ctrl1_q[`DBC_B1_KILL_INT];

   assign trigger_polarity_invert = (function_code == DBC_DUAL_PULSE) && ctrl1_q[`DBC_B1_INV];
   assign dead_time_width = (function_code == DBC_DUAL_PULSE) ?
      ctrl1_q[`DBC_B1_DBW_HI:`DBC_B1_DBW_LO] : 3'h0;

   assign serial_length = (function_code == DBC_SERIAL) ?
      ctrl1_q[`DBC_B1_LEN_HI:`DBC_B1_LEN_LO] : 5'h00;
   assign serial_lsb_block = (function_code == DBC_SERIAL) && ctrl1_q[`DBC_B1_LSB_BLOCK];
   assign serial_chained = (function_code == DBC_SERIAL) && ctrl1_q[`DBC_B1_CHAINED];

endmodule // dbc_ctrl_regs

// >>> hdl/dbc_defs.svh
`ifndef DBC_DEFS_SVH
`define DBC_DEFS_SVH

// Register addresses on the plain register port, reset value and idle read data
`define DBC_ADDR_CTRL0 8'h00
`define DBC_ADDR_CTRL1 8'h01
`define DBC_RESET_VAL 8'h00
`define DBC_READ_NONE 8'h00

// Function codes
`define DBC_FN_TIMER 3'h0
`define DBC_FN_COUNTER 3'h1
`define DBC_FN_CHECKSUM 3'h2
`define DBC_FN_DUAL_PULSE 3'h3
`define DBC_FN_DEAD_TIME 3'h4
`define DBC_FN_ASYNC 3'h5
`define DBC_FN_SERIAL 3'h6
`define DBC_FN_DENSITY 3'h7

// Writable bits of control register 0, per function
`define DBC_WM0_TIMER 8'hFF
`define DBC_WM0_COUNTER 8'hF7
`define DBC_WM0_CHECKSUM 8'hF7
`define DBC_WM0_DUAL_PULSE 8'hFF
`define DBC_WM0_DEAD_TIME 8'h07
`define DBC_WM0_ASYNC 8'h07
`define DBC_WM0_SERIAL 8'h87
`define DBC_WM0_DENSITY 8'hF1

// Writable bits of control register 1, per function
`define DBC_WM1_MULTI 8'hFF
`define DBC_WM1_DEAD_TIME 8'h01
`define DBC_WM1_ASYNC 8'h00
`define DBC_WM1_SERIAL 8'hDF
`define DBC_WM1_DENSITY 8'h09

// Control register 0 bit positions
`define DBC_B0_EN 0
`define DBC_B0_OPT1 1
`define DBC_B0_OPT2 2
`define DBC_B0_OPT3 3
`define DBC_B0_RX_FULL 3
`define DBC_B0_TX_EMPTY 4
`define DBC_B0_COMPLETE 5
`define DBC_B0_OVERRUN 6
`define DBC_B0_RX_ACTIVE 4
`define DBC_B0_FRAMING 5
`define DBC_B0_PARITY_ERR 7
`define DBC_B0_LSB_FIRST 7
`define DBC_B0_SEL_HI 7
`define DBC_B0_SEL_LO 4

// Control register 1 bit positions
`define DBC_B1_KILL_INT 0
`define DBC_B1_MD_HI 2
`define DBC_B1_MD_LO 1
`define DBC_B1_INV 3
`define DBC_B1_RPT_HI 7
`define DBC_B1_RPT_LO 4
`define DBC_B1_DBW_HI 2
`define DBC_B1_DBW_LO 0
`define DBC_B1_LEN_HI 4
`define DBC_B1_LEN_LO 0
`define DBC_B1_LSB_BLOCK 6
`define DBC_B1_CHAINED 7

`endif

// >>> hdl/dbc_pkg.sv
`include "dbc_defs.svh"

package dbc_pkg;

   typedef enum logic [2:0] {
      DBC_TIMER = `DBC_FN_TIMER,
      DBC_COUNTER = `DBC_FN_COUNTER,
      DBC_CHECKSUM = `DBC_FN_CHECKSUM,
      DBC_DUAL_PULSE = `DBC_FN_DUAL_PULSE,
      DBC_DEAD_TIME = `DBC_FN_DEAD_TIME,
      DBC_ASYNC = `DBC_FN_ASYNC,
      DBC_SERIAL = `DBC_FN_SERIAL,
      DBC_DENSITY = `DBC_FN_DENSITY
   } dbc_func_t;

   typedef logic [7:0] dbc_byte_t;

endpackage

// >>> verification/dbc_ctrl_regs_properties.sv
module dbc_ctrl_regs_properties (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire dbc_pkg::dbc_func_t function_code,
   input wire logic prev_primary_out,
   input wire logic spi_overrun,
   input wire logic spi_complete,
   input wire logic spi_tx_empty,
   input wire logic spi_rx_full,
   input wire logic function_enable,
   input wire logic bitbang_mode,
   input wire logic bitbang_clock,
   input wire logic deadband_reference,
   input wire logic [3:0] repeat_count,
   input wire logic [3:0] start_select,
   input wire logic [2:0] dead_time_width,
   input wire logic [4:0] serial_length
);
   import dbc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Write sequences and properties
   // ----------------------------------------
   sequence s_en_on;
      reg_wr && reg_addr == 8'h00 && reg_wdata[0] ##1 !(reg_wr && reg_addr == 8'h00);
   endsequence
   sequence s_en_off;
      reg_wr && reg_addr == 8'h00 && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 8'h00);
   endsequence
   sequence s_len_wr;
      reg_wr && reg_addr == 8'h01 && function_code == DBC_SERIAL
         ##1 !(reg_wr && reg_addr == 8'h01) && function_code == DBC_SERIAL;
   endsequence
   sequence s_bang_wr;
      reg_wr && reg_addr == 8'h00 && reg_wdata[1] && function_code == DBC_DEAD_TIME
         ##1 !(reg_wr && reg_addr == 8'h00) && function_code == DBC_DEAD_TIME;
   endsequence
   property p_en_on;
      s_en_on |=> function_enable;
   endproperty
   property p_en_off;
      s_en_off |=> !function_enable;
   endproperty
   property p_len;
      s_len_wr |=> function_code != DBC_SERIAL || serial_length == $past(reg_wdata[4:0], 2);
   endproperty
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   property p_unmapped;
      reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00;
   endproperty
   property p_spi_status;
      reg_rd && reg_addr == 8'h00 && function_code == DBC_SERIAL |=> reg_rdata[6:3] ==
         {$past(spi_overrun), $past(spi_complete), $past(spi_tx_empty), $past(spi_rx_full)};
   endproperty
   property p_async_c1;
      reg_rd && reg_addr == 8'h01 && function_code == DBC_ASYNC |=> reg_rdata == 8'h00;
   endproperty
   property p_dead_ref;
      function_code != DBC_DEAD_TIME |-> !bitbang_mode && deadband_reference == prev_primary_out;
   endproperty
   property p_bang;
      s_bang_wr |=> function_code != DBC_DEAD_TIME ||
         deadband_reference == $past(reg_wdata[2], 2);
   endproperty
   property p_dens_gate;
      function_code == DBC_DENSITY |-> {repeat_count, start_select, dead_time_width} == 11'h000;
   endproperty
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_en_on: assert property (p_en_on) else $error("enable not set");
   a_en_off: assert property (p_en_off) else $error("enable not cleared");
   a_len: assert property (p_len) else $error("serial length wrong");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   a_spi_status: assert property (p_spi_status) else $error("serial status wrong");
   a_async_c1: assert property (p_async_c1) else $error("async ctrl1 nonzero");
   a_dead_ref: assert property (p_dead_ref) else $error("reference select wrong");
   a_bang: assert property (p_bang) else $error("bit-bang reference wrong");
   a_dens_gate: assert property (p_dens_gate) else $error("density fields leak");
endmodule // dbc_ctrl_regs_properties

bind dbc_ctrl_regs dbc_ctrl_regs_properties i_chk (.ref_clk, .reset, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .function_code, .prev_primary_out, .spi_overrun,
   .spi_complete, .spi_tx_empty, .spi_rx_full, .function_enable, .bitbang_mode,
   .bitbang_clock, .deadband_reference, .repeat_count, .start_select, .dead_time_width,
   .serial_length);

// >>> verification/dbc_ctrl_regs_test.sv
module dbc_ctrl_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dbc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, uart_tx_select = 1'b0, prev_primary_out = 1'b0;
   dbc_func_t function_code = DBC_TIMER;
   logic [10:0] st = 11'h000;
   logic function_enable, deadband_reference;
   logic [3:0] kill_select, repeat_count;
   logic [4:0] serial_length;
   logic [3:0] start_select;
   logic [2:0] dead_time_width;
   logic [1:0] stop_behaviour_select;
   logic capture_int_enable, terminal_count_full_width, compare_extend, compare_value_buffer_en;
   logic pass_mode, shift_mode, software_trigger, no_swallow_option, bitbang_mode;
   logic bitbang_clock, serial_lsb_first, serial_clock_phase, serial_clock_polarity;
   logic parity_enable, parity_odd, stop_polarity_invert, kill_int_select;
   logic trigger_polarity_invert, serial_lsb_block, serial_chained;
   logic [7:0] o0, o1, o2, o3, x0, x1, x2, x3;
   int bad_count = 0, num_checks = 0, cyc = 0, f;
   logic [7:0] d0, d1, e0, e1;
   logic p;

   dbc_ctrl_regs i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .function_code, .uart_tx_select, .prev_primary_out, .spi_rx_full(st[0]),
      .spi_tx_empty(st[1]), .spi_complete(st[2]), .spi_overrun(st[3]), .tx_reg_empty(st[4]),
      .tx_complete(st[5]), .rx_reg_full(st[6]), .rx_active(st[7]), .rx_framing_error(st[8]),
      .rx_overrun(st[9]), .rx_parity_error(st[10]), .function_enable, .kill_select,
      .start_select, .capture_int_enable, .terminal_count_full_width, .compare_extend,
      .compare_value_buffer_en, .pass_mode, .shift_mode, .software_trigger,
      .no_swallow_option, .bitbang_mode, .bitbang_clock, .deadband_reference,
      .serial_lsb_first, .serial_clock_phase, .serial_clock_polarity, .parity_enable,
      .parity_odd, .repeat_count, .stop_polarity_invert, .stop_behaviour_select,
      .kill_int_select, .trigger_polarity_invert, .dead_time_width, .serial_length,
      .serial_lsb_block, .serial_chained);

   // Flag and field outputs gathered into bytes for the byte-wide compare task
   assign o0 = {capture_int_enable, terminal_count_full_width, compare_extend,
      compare_value_buffer_en, pass_mode, shift_mode, software_trigger, no_swallow_option};
   assign o1 = {start_select, bitbang_mode, bitbang_clock, parity_enable, parity_odd};
   assign o2 = {serial_lsb_first, serial_clock_phase, serial_clock_polarity, serial_lsb_block,
      serial_chained, stop_polarity_invert, kill_int_select, trigger_polarity_invert};
   assign o3 = {stop_behaviour_select, dead_time_width, 3'b000};

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [7:0] m0(input int c);
      case (c)
         0, 3: return 8'hFF;
         1, 2: return 8'hF7;
         4, 5: return 8'h07;
         6: return 8'h87;
         default: return 8'hF1;
      endcase
   endfunction

   function automatic logic [7:0] m1(input int c);
      case (c)
         0, 1, 2, 3: return 8'hFF;
         4: return 8'h01;
         5: return 8'h00;
         6: return 8'hDF;
         default: return 8'h09;
      endcase
   endfunction

   // Status bits mirror their inputs and are never stored
   function automatic logic [7:0] sv(input int c);
      if (c == 6) return {1'b0, st[3:0], 3'b000};
      if (c == 5) return uart_tx_select ? {2'b00, st[5:4], 4'h0} : {st[10:6], 3'b000};
      return 8'h00;
   endfunction

   // ----------------------------------------
   // Bus tasks and checks
   // ----------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Strobes stay up across back-to-back calls; idle drops them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, e);
   endtask

   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h8e468567));
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      // Code 8 stands for the receiver flavour of the async function
      for (int c = 0; c < 9; c++) begin
         for (int k = 0; k < 4; k++) begin
            f = (c == 8) ? 5 : c;
            function_code <= dbc_func_t'(f[2:0]);
            uart_tx_select <= (c == 5);
            st <= 11'($urandom);
            p = 1'($urandom);
            prev_primary_out <= p;
            // random bytes for both registers, so in dual pulse no-swallow can meet an active dead band width
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            idle();
            e0 = d0 & m0(f);
            e1 = d1 & m1(f);
            wr(8'h00, d0);
            wr(8'h02 + 8'(c), ~d0);
            rd(8'h00, e0 | sv(f));
            wr(8'h01, d1);
            rd(8'h01, e1);
            rd(8'hFE, 8'h00);
            idle();
            chk(reg_rdata, 8'h00);
            chk({7'h00, function_enable}, {7'h00, e0[0]});
            chk({4'h0, kill_select}, (f inside {0, 1, 2, 7}) ? {4'h0, e0[7:4]} : 8'h00);
            x0 = {f == 0 && e0[1], f == 0 && e0[2],
               (f == 0) ? e0[3] : (f == 1 || f == 3) && e0[2], f == 1 && e0[1],
               f == 2 && e0[1], f == 2 && e0[2], f == 3 && e0[1], f == 3 && e0[3]};
            x1 = {f == 3 ? e0[7:4] : 4'h0, f == 4 && e0[1], f == 4 && e0[2],
               f == 5 && e0[1], f == 5 && e0[2]};
            x2 = {f == 6 && e0[7], f == 6 && e0[2], f == 6 && e0[1], f == 6 && e1[6],
               f == 6 && e1[7], (f < 3 || f == 7) && e1[3],
               (f < 3 || f == 4 || f == 7) && e1[0], f == 3 && e1[3]};
            x3 = {f < 3 ? e1[2:1] : 2'h0, f == 3 ? e1[2:0] : 3'h0, 3'h0};
            chk(o0, x0);
            chk(o1, x1);
            chk(o2, x2);
            chk(o3, x3);
            chk({4'h0, repeat_count}, f < 4 ? {4'h0, e1[7:4]} : 8'h00);
            chk({3'h0, serial_length}, f == 6 ? {3'h0, e1[4:0]} : 8'h00);
            chk({7'h00, deadband_reference}, {7'h00, (f == 4 && e0[1]) ? e0[2] : p});
         end
      end
      reset <= 1'b1;
      idle();
      reset <= 1'b0;
      rd(8'h00, sv(f));
      rd(8'h01, 8'h00);
      idle();
      chk({7'h00, function_enable}, 8'h00);
      chk(o0 | o1 | o2 | o3, 8'h00);
      end_sim();
   end
endmodule // dbc_ctrl_regs_test
